// [include/irs_pkg.sv]
/*
  Shared constants and carrier types for the two-wire register target port.
  Assumes one register bank on the system clock and a separate sampling
  clock for the link-facing logic.
*/
package irs_pkg;

  // Target address after reset (seven bits, direction bit excluded)
  localparam logic [6:0] IRS_ADDR_RST    = 7'h18;
  // Register pointer value after reset
  localparam logic [7:0] IRS_PTR_RST     = 8'h00;
  // Value returned for an address the bank does not implement
  localparam logic [7:0] IRS_UNIMPL_DATA = 8'h00;
  // Bits per byte on the wire
  localparam logic [3:0] IRS_BYTE_BITS   = 4'h8;
  // Highest serial clock rate supported, in kHz
  localparam int         IRS_SCL_MAX_KHZ = 3400;

  // Link-side protocol states
  typedef enum logic [3:0] {
    IRS_IDLE,
    IRS_ADDR,
    IRS_ADDR_ACK,
    IRS_PTR,
    IRS_PTR_ACK,
    IRS_WR,
    IRS_WR_ACK,
    IRS_RD,
    IRS_RD_ACK,
    IRS_IGNORE
  } irs_state_t;

  // Bank-side phases
  typedef enum logic [0:0] {
    IRS_B_IDLE,
    IRS_B_ACT
  } irs_bph_t;

  // One request sent from the link to the bank
  typedef struct packed {
    logic       wr;
    logic [7:0] ptr;
    logic [7:0] data;
  } irs_req_t;

  // Complete link-domain state
  typedef struct packed {
    irs_state_t st;
    logic       p_scl;
    logic       p_sda;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic       dir;
    logic       nack;
    logic       sda_oe;
    logic       sda_o;
    logic       busy;
    logic       req_tgl;
    irs_req_t   req;
    logic       ans_seen;
    logic [7:0] ans;
  } irs_lnk_t;

  // Complete bank-domain state
  typedef struct packed {
    irs_bph_t   ph;
    logic       req_seen;
    logic       ack_tgl;
    logic [7:0] ans;
    logic [7:0] reg_ptr;
    logic [7:0] wr_data;
    logic       wr_pend;
    logic       wr_stb;
  } irs_bnk_t;

endpackage

// [rtl/irs_port.sv]
/*
  Two-wire serial target port giving an external controller byte access
  to a register bank. The protocol engine runs on link_clk, which samples
  SCL and SDA; the bank interface runs on mclk. Requests and answers cross
  by toggle handshake with payloads held stable while in flight.
  Assumes open-drain SDA resolved outside, link_clk well above SCL rate,
  and a bank that answers reg_hit and rd_data combinationally on reg_ptr.

*/
`timescale 1ns/1ps
module irs_port
  import irs_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = IRS_ADDR_RST
) (
  // System clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // Link sampling clock
  input  wire logic       link_clk,
  // Two-wire bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  output logic            bus_busy,
  // Register bank side
  output logic      [7:0] reg_ptr,
  output logic      [7:0] wr_data,
  output logic            wr_stb,
  input  wire logic [7:0] rd_data,
  input  wire logic       reg_hit,
  input  wire logic       dev_busy
);

  irs_lnk_t l_q;
  irs_lnk_t l_d;
  irs_bnk_t b_q;
  irs_bnk_t b_d;

  logic       scl_s;
  logic       sda_s;
  logic       lrst;
  logic       busy_s;
  logic       ack_s;
  logic       req_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       addr_ok;

  // Pins and bank status reach the link logic through two flops
  irs_sync #(.W(4)) u_sync_lnk (
    .clk (link_clk),
    .d   ({scl_i, sda_i, dev_busy, b_q.ack_tgl}),
    .q   ({scl_s, sda_s, busy_s, ack_s})
  );

  // Reset is carried into the link domain as a level
  irs_sync #(.W(1)) u_sync_rst (
    .clk (link_clk),
    .d   (srst),
    .q   (lrst)
  );

  // Request toggle reaches the bank domain
  irs_sync #(.W(1)) u_sync_req (
    .clk (mclk),
    .d   (l_q.req_tgl),
    .q   (req_s)
  );

  // Bus events from the synchronised lines; a 30 ns sample clock gives
  // only two samples of a 60 ns SCL high, so high-speed mode is marginal
  assign scl_rise = scl_s & ~l_q.p_scl;
  assign scl_fall = ~scl_s & l_q.p_scl;
  assign start_c  = scl_s & l_q.p_scl & l_q.p_sda & ~sda_s;
  assign stop_c   = scl_s & l_q.p_scl & ~l_q.p_sda & sda_s;

  // Address check on the completed first byte
  assign addr_ok  = (l_q.sh[7:1] == OWN_ADDR) && !busy_s;

  // Link protocol engine
  always_comb
  begin
    l_d       = l_q;
    l_d.p_scl = scl_s;
    l_d.p_sda = sda_s;
    l_d.sda_o = 1'b0;
    // Latch the bank answer once its toggle has settled here
    if (ack_s != l_q.ans_seen)
    begin
      l_d.ans_seen = ack_s;
      l_d.ans      = b_q.ans;
    end
    if (start_c)
    begin
      // Start or repeated start restarts byte framing, bus stays busy
      l_d.st     = IRS_ADDR;
      l_d.cnt    = 4'h0;
      l_d.busy   = 1'b1;
      l_d.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      // A byte cut short never reaches the bank
      l_d.st     = IRS_IDLE;
      l_d.busy   = 1'b0;
      l_d.sda_oe = 1'b0;
    end
    else
    begin
      case (l_q.st)
        IRS_ADDR, IRS_PTR, IRS_WR:
        begin
          // Receive MSB first on rising SCL
          if (scl_rise && l_q.cnt != IRS_BYTE_BITS)
          begin
            l_d.sh  = {l_q.sh[6:0], sda_s};
            l_d.cnt = l_q.cnt + 4'h1;
          end
          if (scl_fall && l_q.cnt == IRS_BYTE_BITS)
          begin
            if (l_q.st == IRS_ADDR)
            begin
              if (addr_ok)
              begin
                l_d.sda_oe = 1'b1;
                l_d.dir    = l_q.sh[0];
                l_d.st     = IRS_ADDR_ACK;
                if (l_q.sh[0])
                begin
                  // Fetch the first read byte during the ack clock
                  l_d.req     = '{wr: 1'b0, ptr: l_q.ptr, data: 8'h00};
                  l_d.req_tgl = ~l_q.req_tgl;
                end
              end
              else
              begin
                l_d.st = IRS_IGNORE;
              end
            end
            else if (busy_s)
            begin
              // Busy mid-transaction: refuse the byte and leave SDA released
              l_d.st = IRS_IGNORE;
            end
            else if (l_q.st == IRS_PTR)
            begin
              l_d.ptr    = l_q.sh;
              l_d.sda_oe = 1'b1;
              l_d.st     = IRS_PTR_ACK;
            end
            else
            begin
              // Whole data byte: commit, ack even if unimplemented
              l_d.req     = '{wr: 1'b1, ptr: l_q.ptr, data: l_q.sh};
              l_d.req_tgl = ~l_q.req_tgl;
              l_d.ptr     = l_q.ptr + 8'h01;
              l_d.sda_oe  = 1'b1;
              l_d.st      = IRS_WR_ACK;
            end
          end
        end
        IRS_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            l_d.cnt = 4'h0;
            if (l_q.dir)
            begin
              // Drive first data bit as the ack clock ends
              l_d.tx     = l_q.ans;
              l_d.sda_oe = ~l_q.ans[7];
              l_d.st     = IRS_RD;
            end
            else
            begin
              l_d.sda_oe = 1'b0;
              l_d.st     = IRS_PTR;
            end
          end
        end
        IRS_PTR_ACK, IRS_WR_ACK:
        begin
          // Release after the ack clock, next byte is data
          if (scl_fall)
          begin
            l_d.sda_oe = 1'b0;
            l_d.cnt    = 4'h0;
            l_d.st     = IRS_WR;
          end
        end
        IRS_RD:
        begin
          if (scl_rise)
          begin
            l_d.cnt = l_q.cnt + 4'h1;
          end
          if (scl_fall)
          begin
            if (l_q.cnt == IRS_BYTE_BITS)
            begin
              // Release for the controller's ack, prefetch next byte
              l_d.sda_oe  = 1'b0;
              l_d.ptr     = l_q.ptr + 8'h01;
              l_d.req     = '{wr: 1'b0, ptr: l_q.ptr + 8'h01, data: 8'h00};
              l_d.req_tgl = ~l_q.req_tgl;
              l_d.st      = IRS_RD_ACK;
            end
            else
            begin
              // Change data only while SCL is low
              l_d.tx     = {l_q.tx[6:0], 1'b0};
              l_d.sda_oe = ~l_q.tx[6];
            end
          end
        end
        IRS_RD_ACK:
        begin
          if (scl_rise)
          begin
            l_d.nack = sda_s;
          end
          if (scl_fall)
          begin
            l_d.cnt = 4'h0;
            if (l_q.nack)
            begin
              // Controller is done; stay off the line until the next start or stop
              l_d.sda_oe = 1'b0;
              l_d.st     = IRS_IGNORE;
            end
            else
            begin
              l_d.tx     = l_q.ans;
              l_d.sda_oe = ~l_q.ans[7];
              l_d.st     = IRS_RD;
            end
          end
        end
        IRS_IGNORE, IRS_IDLE:
        begin
          l_d.sda_oe = 1'b0;
        end
        default:
        begin
          l_d.st     = IRS_IDLE;
          l_d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Link registers; the pointer survives between transactions
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      l_q          <= '0;
      l_q.st       <= IRS_IDLE;
      l_q.p_scl    <= 1'b1;
      l_q.p_sda    <= 1'b1;
      l_q.ptr      <= IRS_PTR_RST;
    end
    else
    begin
      l_q <= l_d;
    end
  end

  // Bank agent: set pointer, then write or capture read data
  always_comb
  begin
    b_d        = b_q;
    b_d.wr_stb = 1'b0;
    case (b_q.ph)
      IRS_B_IDLE:
      begin
        if (req_s != b_q.req_seen)
        begin
          // Payload has been stable since the toggle left the link side
          b_d.req_seen = req_s;
          b_d.reg_ptr  = l_q.req.ptr;
          b_d.wr_data  = l_q.req.data;
          b_d.wr_pend  = l_q.req.wr;
          b_d.ph       = IRS_B_ACT;
        end
      end
      IRS_B_ACT:
      begin
        if (b_q.wr_pend)
        begin
          b_d.wr_stb = reg_hit;
        end
        else
        begin
          b_d.ans = reg_hit ? rd_data : IRS_UNIMPL_DATA;
        end
        b_d.ack_tgl = ~b_q.ack_tgl;
        b_d.ph      = IRS_B_IDLE;
      end
      default:
      begin
        b_d.ph = IRS_B_IDLE;
      end
    endcase
  end

  // Bank registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      b_q         <= '0;
      b_q.ph      <= IRS_B_IDLE;
      b_q.reg_ptr <= IRS_PTR_RST;
    end
    else
    begin
      b_q <= b_d;
    end
  end

  // Every output comes straight from a flop
  assign sda_o    = l_q.sda_o;
  assign sda_oe   = l_q.sda_oe;
  assign bus_busy = l_q.busy;
  assign reg_ptr  = b_q.reg_ptr;
  assign wr_data  = b_q.wr_data;
  assign wr_stb   = b_q.wr_stb;

endmodule

// [rtl/irs_sync.sv]
/*
  Two-flop level synchroniser, any width.
  Assumes each bit is an independent level or a toggle that is held
  long enough to be seen; multi-bit words must not change while in flight.
*/
`timescale 1ns/1ps
module irs_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } irs_sync_st_t;

  irs_sync_st_t s_q;
  irs_sync_st_t s_d;

  // First stage feeds only the second stage
  always_comb
  begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.q    = s_q.meta;
  end

  // No reset: a synchroniser carries no control state of its own
  always_ff @(posedge clk)
  begin
    s_q <= s_d;
  end

  assign q = s_q.q;

endmodule

// [tb/irs_ctl_model.sv]
/* Behavioural bus controller for the port's far side.
   Assumes a pull-up on SDA resolved by the bench. */
`timescale 1ns/1ps
module irs_ctl_model (
  // Clock level and data pull (high pulls SDA low)
  output logic      scl,
  output logic      sda_low,
  // Resolved data wire
  input  wire logic sda
);
  int hp = 210; // SCL half period in ns; slowed by the bench
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start; SCL stands high between frames
  task automatic start();
    sda_low = 1'b0;
    #(hp) scl = 1'b1;
    #(hp) sda_low = 1'b1;
    #(hp) scl = 1'b0;
    #(hp / 2);
  endtask
  // Stop frees the bus
  task automatic stop();
    sda_low = 1'b1;
    #(hp / 2) scl = 1'b1;
    #(hp) sda_low = 1'b0;
    #(hp);
  endtask
  // Data moves mid-low only, sampled at the end of high
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #(hp / 2) scl = 1'b1;
    #(hp) r = sda;
    scl = 1'b0;
    #(hp / 2);
  endtask
  // Byte out, then SDA released for the acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then acknowledge or refuse it
  task automatic get(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

// [tb/irs_port_chk.sv]
/* Port checker for irs_port, bound below.
   Assumes the bench keeps SCL phases at least seven link clocks. */
`timescale 1ns/1ps
module irs_port_chk
  import irs_pkg::*;
(
  // Clocks and reset
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       link_clk,
  // Bus pins
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       bus_busy,
  // Bank side
  input wire logic [7:0] reg_ptr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_stb,
  input wire logic [7:0] rd_data,
  input wire logic       reg_hit,
  input wire logic       dev_busy
);
  // Link side
  property p_hold; @(posedge link_clk) disable iff (srst) scl_i && $past(scl_i) |-> $stable(sda_oe); endproperty
  a_hold: assert property (p_hold) else $error("pull moved with SCL high");
  property p_beg; @(posedge link_clk) disable iff (srst) $rose(bus_busy) |-> scl_i && !sda_i; endproperty
  a_beg: assert property (p_beg) else $error("busy without start");
  property p_end; @(posedge link_clk) disable iff (srst) $fell(bus_busy) |-> scl_i && sda_i; endproperty
  a_end: assert property (p_end) else $error("free without stop");
  property p_idle; @(posedge link_clk) disable iff (srst) !bus_busy |-> !sda_oe; endproperty
  a_idle: assert property (p_idle) else $error("pull on a free bus");
  property p_ack; @(posedge link_clk) disable iff (srst) $rose(sda_oe) |-> !scl_i; endproperty
  a_ack: assert property (p_ack) else $error("pull began with SCL high");
  // Busy long enough to be synced: no pull may begin
  property p_busy; @(posedge link_clk) disable iff (srst)
    dev_busy && $past(dev_busy, 4) && $past(dev_busy, 8) |-> !$rose(sda_oe); endproperty
  a_busy: assert property (p_busy) else $error("acknowledged while busy");
  // Bank side
  property p_pulse; @(posedge mclk) disable iff (srst) wr_stb |=> !wr_stb && $stable(reg_ptr); endproperty
  a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
  property p_hit; @(posedge mclk) disable iff (srst) wr_stb |-> reg_hit && $stable(wr_data); endproperty
  a_hit: assert property (p_hit) else $error("strobe to a missing register");
  property p_rst; @(posedge mclk) srst |=> reg_ptr == IRS_PTR_RST && !wr_stb; endproperty
  a_rst: assert property (p_rst) else $error("pointer not cleared by reset");
  c_wr: cover property (@(posedge mclk) wr_stb);
  c_busy: cover property (@(posedge link_clk) $rose(bus_busy));
  c_pull: cover property (@(posedge link_clk) $rose(sda_oe));
endmodule

bind irs_port irs_port_chk CHK (.mclk(mclk), .srst(srst), .link_clk(link_clk), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .bus_busy(bus_busy), .reg_ptr(reg_ptr), .wr_data(wr_data),
  .wr_stb(wr_stb), .rd_data(rd_data), .reg_hit(reg_hit), .dev_busy(dev_busy));

// [tb/irs_port_test.sv]
/* Self-checking bench for irs_port with a controller model.
   Bank of eight registers; the rest of the map is missing. */
`timescale 1ns/1ps
module irs_port_test;
  import irs_pkg::*;
  logic        mclk, srst, link_clk, dev_busy, reg_hit, sda_o, sda_oe, bus_busy, wr_stb, scl, m_low, a;
  logic [7:0]  reg_ptr, wr_data, rd_data;
  logic [7:0]  mem [0:7];
  logic [7:0]  shadow [0:7];
  logic [15:0] wq [$];
  int          fail_count = 0;
  int          n_compared = 0;
  int          seed = 32'h75c61151;
  wire         sda = !((sda_oe && !sda_o) || m_low); // Pull-up unless someone pulls
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = !link_clk;
  end
  irs_ctl_model P (.scl(scl), .sda_low(m_low), .sda(sda));
  irs_port DUT (.mclk(mclk), .srst(srst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .bus_busy(bus_busy), .reg_ptr(reg_ptr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_data(rd_data), .reg_hit(reg_hit), .dev_busy(dev_busy));
  // Bank model; junk off the map proves the port substitutes zero
  assign reg_hit = reg_ptr < 8'h08;
  assign rd_data = reg_hit ? mem[reg_ptr[2:0]] : 8'ha5;
  task automatic cmp(input logic [15:0] g, input logic [15:0] e, input string k);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, k, g, e);
    end
  endtask
  task automatic chk_wr(input logic [15:0] g, input logic [15:0] e);
    cmp(g, e, "write");
  endtask
  task automatic chk_rd(input logic [7:0] g, input logic [7:0] e);
    cmp({8'h00, g}, {8'h00, e}, "read");
  endtask
  task automatic chk_ack(input logic g, input logic e);
    cmp({15'h0000, g}, {15'h0000, e}, "ack");
  endtask
  task automatic chk_busy(input logic g, input logic e);
    cmp({15'h0000, g}, {15'h0000, e}, "busy");
  endtask
  // Each strobe takes the oldest noted write; looked at mid-cycle while it stands
  always @(negedge mclk)
  begin
    if (wr_stb === 1'b1)
    begin
      mem[reg_ptr[2:0]] <= wr_data;
      chk_wr({reg_ptr, wr_data}, wq.size() > 0 ? wq.pop_front() : 16'hxxxx);
    end
  end
  task automatic snd(input logic [7:0] d, input logic e);
    logic k;
    P.put(d, k);
    chk_ack(k, e);
  endtask
  // Start, address, pointer, then n random bytes; no stop
  task automatic wr_at(input logic [7:0] p, input int n);
    logic [7:0] d;
    P.start();
    chk_busy(bus_busy, 1'b1);
    snd({IRS_ADDR_RST, 1'b0}, 1'b1);
    snd(p, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      if (p < 8'h08)
        wq.push_back({p, d});
      if (p < 8'h08)
        shadow[p[2:0]] = d;
      snd(d, 1'b1);
      p++;
    end
  endtask
  task automatic rd_n(input logic [7:0] p, input int n);
    logic [7:0] d;
    P.start();
    chk_busy(bus_busy, 1'b1);
    snd({IRS_ADDR_RST, 1'b1}, 1'b1);
    for (int i = 1; i <= n; i++)
    begin
      P.get(i < n, d);
      chk_rd(d, p < 8'h08 ? shadow[p[2:0]] : IRS_UNIMPL_DATA);
      p++;
    end
    P.stop();
    // A port still pulling SDA after the refusal would hide the stop
    chk_busy(bus_busy, 1'b0);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Longest run is about 300 us
  initial
  begin
    #800000;
    fail_count++;
    results();
  end
  initial
  begin
    srst = 1'b1;
    dev_busy = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      mem[i] = 8'($random(seed));
      shadow[i] = mem[i];
    end
    // Longer than eight cycles so the link side sees reset
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    repeat (20) @(negedge mclk);
    for (int r = 0; r < 2; r++)
    begin
      P.hp = r == 0 ? 210 : 500;
      wr_at(8'h06, 3);
      P.stop();
      wr_at(8'h06, 0);
      rd_n(8'h06, 3);
    end
    wr_at(8'h02, 1);
    repeat (4) P.bit_io(1'b0, a);
    P.stop();
    wr_at(8'hff, 2);
    P.stop();
    rd_n(8'h01, 2);
    P.start();
    snd({IRS_ADDR_RST + 7'h01, 1'b0}, 1'b0);
    P.stop();
    @(negedge mclk) dev_busy = 1'b1;
    repeat (10) @(negedge mclk);
    P.start();
    snd({IRS_ADDR_RST, 1'b0}, 1'b0);
    P.stop();
    @(negedge mclk) dev_busy = 1'b0;
    repeat (20) @(negedge mclk);
    chk_wr(16'(wq.size()), 16'h0000);
    results();
  end
endmodule
